// ==== rtl/debug_command_interpreter.sv ====
// byte command interpreter of the on-chip debug unit
`include "dbg_cmd_params.svh"

module debug_command_interpreter #(
  parameter logic [15:0] REVISION = `REV_DEFAULT, // arbitrary value
  parameter int CNT_WIDTH = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // received command and data bytes from the link framer
  input wire dbg_cmd_pkg::byte_strobe_t rx_i,
  output logic rx_ready_o,
  // reply bytes to the link framer
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // device state
  input wire logic read_protect_i,
  input wire logic [7:0] debug_status_register_i,
  input wire logic cpu_running_i,
  // control and command strobes
  output logic [7:0] debug_control_register_o,
  output dbg_cmd_pkg::cmd_pulses_t cmd_pulse_o
);
  import dbg_cmd_pkg::*;

  cmd_regs_t r_r;
  cmd_regs_t r_nxt;
  logic [CNT_WIDTH-1:0] cnt;
  logic rx_take;

  cycle_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_counter (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .run_i(cpu_running_i),
    .clear_i(r_r.cnt_clear),
    .cnt_o(cnt)
  );

  // no new byte while a reply is still going out
  assign rx_ready_o = (r_r.st == ST_IDLE) || (r_r.st == ST_GET_CTL);
  assign rx_take = rx_i.valid && rx_ready_o;

  always_comb begin
    r_nxt = r_r;
    r_nxt.pulse = '0;
    r_nxt.cnt_clear = 1'b0;
    case (r_r.st)
      ST_IDLE: begin
        if (rx_take) begin
          case (rx_i.data)
            `CMD_READ_REV: begin
              r_nxt.tx_data = REVISION[15:8]; // R3
              r_nxt.pend_lo = REVISION[7:0]; // R3
              r_nxt.tx_valid = 1'b1;
              r_nxt.st = ST_SEND_HI;
            end
            `CMD_READ_STATUS: begin
              r_nxt.tx_data = debug_status_register_i; // R4
              r_nxt.tx_valid = 1'b1;
              r_nxt.st = ST_SEND_ONE;
            end
            `CMD_READ_COUNTER: begin
              // both halves taken in one cycle so the pair is coherent
              r_nxt.tx_data = cnt[15:8]; // R7
              r_nxt.pend_lo = cnt[7:0]; // R7
              r_nxt.tx_valid = 1'b1;
              r_nxt.st = ST_SEND_HI;
            end
            `CMD_WRITE_CTL: begin
              r_nxt.st = ST_GET_CTL; // R8
            end
            `CMD_CRC: begin
              r_nxt.pulse.crc_start = 1'b1; // R1
              r_nxt.cnt_clear = 1'b1; // R6
            end
            `CMD_STEP, `CMD_STUFF, `CMD_EXEC: begin
              if (!read_protect_i) begin
                r_nxt.pulse.step = (rx_i.data == `CMD_STEP); // R2
                r_nxt.pulse.stuff = (rx_i.data == `CMD_STUFF); // R2
                r_nxt.pulse.exec = (rx_i.data == `CMD_EXEC); // R2
                r_nxt.cnt_clear = 1'b1; // R6
              end
            end
            default: begin
              // reserved codes are dropped silently
              if (rx_i.data != `CMD_RSVD_LOW && rx_i.data < `CMD_RSVD_FIRST) begin // R1 R10
                r_nxt.pulse.ext_cmd = 1'b1;
                r_nxt.pulse.ext_code = rx_i.data;
                // memory and register commands sit from this code upward
                r_nxt.cnt_clear = (rx_i.data >= `CMD_OVERWRITE_FIRST); // R6
              end
            end
          endcase
        end
      end
      ST_GET_CTL: begin
        if (rx_take) begin
          r_nxt.ctl = rx_i.data; // R8
          if (read_protect_i) begin
            // debug mode bit is sticky under protection
            r_nxt.ctl[`CTL_MODE_BIT] = r_r.ctl[`CTL_MODE_BIT] | rx_i.data[`CTL_MODE_BIT]; // R9
          end
          r_nxt.st = ST_IDLE;
        end
      end
      ST_SEND_HI: begin
        if (tx_ready_i) begin
          r_nxt.tx_data = r_r.pend_lo; // R3 R7
          r_nxt.st = ST_SEND_LO;
        end
      end
      ST_SEND_ONE, ST_SEND_LO: begin
        if (tx_ready_i) begin
          r_nxt.tx_valid = 1'b0;
          r_nxt.st = ST_IDLE;
        end
      end
      default: begin
        r_nxt.st = ST_IDLE;
        r_nxt.tx_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_r <= '{st: ST_IDLE, ctl: `CTL_RESET, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign tx_valid_o = r_r.tx_valid;
  assign tx_data_o = r_r.tx_data;
  assign debug_control_register_o = r_r.ctl;
  assign cmd_pulse_o = r_r.pulse;

  a_rev_major: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R3
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_READ_REV) |=> (tx_valid_o && tx_data_o == REVISION[15:8]))
    else $error("revision major byte wrong");
  a_rev_minor: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R3
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_READ_REV) ##1 tx_ready_i
      |=> (tx_valid_o && tx_data_o == REVISION[7:0]))
    else $error("revision minor byte wrong");
  a_status_byte: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R4
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_READ_STATUS)
      |=> (tx_valid_o && tx_data_o == $past(debug_status_register_i)))
    else $error("status byte wrong");
  a_cnt_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R7
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_READ_COUNTER)
      |=> (tx_valid_o && tx_data_o == $past(cnt[15:8])))
    else $error("counter high byte wrong");
  a_ctl_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R8
    (rx_take && r_r.st == ST_GET_CTL && !read_protect_i) |=> (debug_control_register_o == $past(rx_i.data)))
    else $error("control byte not written");
  a_mode_lock: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R9
    (read_protect_i && debug_control_register_o[`CTL_MODE_BIT]) |=> debug_control_register_o[`CTL_MODE_BIT])
    else $error("debug mode bit cleared under protection");
  a_exec_refuse: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R2
    (rx_take && r_r.st == ST_IDLE && read_protect_i && rx_i.data >= `CMD_STEP && rx_i.data <= `CMD_EXEC)
      |=> !(cmd_pulse_o.step || cmd_pulse_o.stuff || cmd_pulse_o.exec) [*2])
    else $error("protected command not refused");
  a_crc_start: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R1
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_CRC) |=> (cmd_pulse_o.crc_start && rx_ready_o))
    else $error("crc command not decoded");
  a_rsvd_drop: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R10
    (rx_take && r_r.st == ST_IDLE && (rx_i.data == `CMD_RSVD_LOW || rx_i.data >= `CMD_RSVD_FIRST))
      |=> (!tx_valid_o && rx_ready_o && cmd_pulse_o == '0))
    else $error("reserved code not ignored");
  // reply bytes stay put until taken, and no byte comes in meanwhile
  a_reply_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R3
    (tx_valid_o && !tx_ready_i) |=> (tx_valid_o && $stable(tx_data_o)))
    else $error("reply byte changed before it was taken");
  a_busy_no_take: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R3
    tx_valid_o |-> !rx_ready_o)
    else $error("byte accepted while a reply is pending");
  a_reply_end: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R3
    (tx_valid_o && tx_ready_i && r_r.st != ST_SEND_HI) |=> (!tx_valid_o && rx_ready_o))
    else $error("reply did not end after its last byte");
  a_status_single: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R4
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_READ_STATUS) ##1 tx_ready_i
      |=> !tx_valid_o)
    else $error("status reply longer than one byte");
  a_cnt_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R7
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_READ_COUNTER) ##1 tx_ready_i
      |=> (tx_valid_o && tx_data_o == $past(cnt[7:0], 2)))
    else $error("counter low byte wrong");
  // command strobes and counter overwrite
  a_pulse_onehot: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R2
    $onehot0({cmd_pulse_o.crc_start, cmd_pulse_o.step, cmd_pulse_o.stuff,
      cmd_pulse_o.exec, cmd_pulse_o.ext_cmd}))
    else $error("more than one command strobe at once");
  a_ext_code: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R1
    (rx_take && r_r.st == ST_IDLE && rx_i.data > `CMD_WRITE_CTL && rx_i.data < `CMD_CRC)
      |=> (cmd_pulse_o.ext_cmd && cmd_pulse_o.ext_code == $past(rx_i.data)))
    else $error("passed-on command code wrong");
  a_step_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R6
    (rx_take && r_r.st == ST_IDLE && !read_protect_i && rx_i.data >= `CMD_STEP && rx_i.data <= `CMD_EXEC)
      |=> ##1 (cnt == '0))
    else $error("counter not overwritten by step command");
  a_crc_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R6
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_CRC) |=> ##1 (cnt == '0))
    else $error("counter not overwritten by crc command");
  a_refuse_keep: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R2
    (rx_take && r_r.st == ST_IDLE && read_protect_i && rx_i.data >= `CMD_STEP && rx_i.data <= `CMD_EXEC)
      |=> !r_r.cnt_clear)
    else $error("refused command overwrote the counter");
  // control register
  a_ctl_protect: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R9
    (rx_take && r_r.st == ST_GET_CTL && read_protect_i)
      |=> (debug_control_register_o[6:0] == $past(rx_i.data[6:0])
        && debug_control_register_o[`CTL_MODE_BIT]
          == ($past(debug_control_register_o[`CTL_MODE_BIT]) | $past(rx_i.data[`CTL_MODE_BIT]))))
    else $error("protected control write wrong");
  a_ctl_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R8
    !(rx_take && r_r.st == ST_GET_CTL) |=> $stable(debug_control_register_o))
    else $error("control register changed without a write");
  a_ctl_done: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R8
    (rx_take && r_r.st == ST_GET_CTL) |=> (rx_ready_o && !tx_valid_o))
    else $error("control write left the interpreter busy");

  c_rev_read: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    (r_r.st == ST_SEND_LO && tx_ready_i));
  c_ctl_write: cover property (@(posedge mclk_i) disable iff (!rst_b_i) (rx_take && r_r.st == ST_GET_CTL));
  c_refused: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rx_take && r_r.st == ST_IDLE && read_protect_i && rx_i.data == `CMD_STEP));
  c_counter_read: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rx_take && r_r.st == ST_IDLE && rx_i.data == `CMD_READ_COUNTER));

endmodule // debug_command_interpreter

// ==== rtl/dbg_cmd_params.svh ====
// command codes, revision default and counter limits of the debug command interpreter
// Summary of operation
// R1 - Byte 0EH starts a program memory CRC read, and codes 0FH and 13H to FFH are reserved and never sent by the host.
// R2 - Codes 10H, 11H and 12H are step, stuff and execute, and all three are refused while flash read protection is on.
// R3 - Command 00H returns the 16-bit debugger revision as the major byte (15:8) followed by the minor byte (7:0).
// R4 - Command 02H returns one byte that holds all eight bits of the debug status register.
// R5 - A 16-bit breakpoint cycle counter counts system clocks between breakpoints from 0000H and stops at FFFFH.
// R6 - Memory, register, CRC, step, stuff and execute commands may overwrite the breakpoint cycle counter.
// R7 - Command 03H returns the breakpoint cycle counter as its high byte followed by its low byte.
// R8 - Command 04H is followed by one data byte that is written into the 8-bit debug control register.
// R9 - Under flash read protection the debug mode bit (control bit 7) may be set but never cleared until reset.
// R10 - A reserved command code is dropped with no reply and the interpreter waits for the next command byte.
`ifndef DBG_CMD_PARAMS_SVH
`define DBG_CMD_PARAMS_SVH

`define CMD_READ_REV 8'h00
`define CMD_READ_STATUS 8'h02
`define CMD_READ_COUNTER 8'h03
`define CMD_WRITE_CTL 8'h04
`define CMD_CRC 8'h0e
`define CMD_RSVD_LOW 8'h0f
`define CMD_STEP 8'h10
`define CMD_STUFF 8'h11
`define CMD_EXEC 8'h12
`define CMD_RSVD_FIRST 8'h13
`define CMD_OVERWRITE_FIRST 8'h08
`define CTL_RESET 8'h00
`define CTL_MODE_BIT 7
`define REV_DEFAULT 16'h0100
`define CNT_ZERO 16'h0000
`define CNT_MAX 16'hffff

`endif

// ==== rtl/dbg_cmd_pkg.sv ====
// types shared by the debug command interpreter and its cycle counter
package dbg_cmd_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_strobe_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GET_CTL,
    ST_SEND_ONE,
    ST_SEND_HI,
    ST_SEND_LO
  } cmd_state_t;

  typedef struct packed {
    logic crc_start;
    logic step;
    logic stuff;
    logic exec;
    logic ext_cmd;
    logic [7:0] ext_code;
  } cmd_pulses_t;

  typedef struct packed {
    cmd_state_t st;
    logic [7:0] ctl;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [7:0] pend_lo;
    cmd_pulses_t pulse;
    logic cnt_clear;
  } cmd_regs_t;

  typedef struct packed {
    logic run_q;
    logic [15:0] cnt;
  } cnt_regs_t;

endpackage

// ==== rtl/cycle_counter.sv ====
// saturating breakpoint cycle counter
`include "dbg_cmd_params.svh"

module cycle_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // control
  input wire logic run_i,
  input wire logic clear_i,
  // count
  output logic [WIDTH-1:0] cnt_o
);
  import dbg_cmd_pkg::*;

  cnt_regs_t r_r;
  cnt_regs_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.run_q = run_i;
    if (clear_i || (run_i && !r_r.run_q)) begin
      r_nxt.cnt = `CNT_ZERO; // R5 R6
    end else if (run_i && r_r.cnt != `CNT_MAX) begin
      r_nxt.cnt = r_r.cnt + 16'h0001; // R5
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign cnt_o = r_r.cnt[WIDTH-1:0];

  a_cnt_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R5
    (r_r.cnt == `CNT_MAX && !clear_i && r_r.run_q) |=> (r_r.cnt == `CNT_MAX))
    else $error("counter left its maximum");
  a_cnt_step: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R5
    (run_i && r_r.run_q && !clear_i && r_r.cnt != `CNT_MAX) |=> (r_r.cnt == $past(r_r.cnt) + 16'h0001))
    else $error("counter did not advance by one");
  a_cnt_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R6
    clear_i |=> (r_r.cnt == `CNT_ZERO))
    else $error("counter not cleared by overwrite");
  c_cnt_sat: cover property (@(posedge mclk_i) disable iff (!rst_b_i) r_r.cnt == `CNT_MAX);

endmodule // cycle_counter

// ==== tb/host_link_model.sv ====
// host adapter model that offers command bytes and takes reply bytes
module host_link_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // byte path to the interpreter
  output dbg_cmd_pkg::byte_strobe_t rx_o,
  input wire logic rx_ready_i,
  // reply path
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // pacing
  input wire logic stall_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbg_cmd_pkg::*;
  logic [1:0] ph_r = 2'h0;
  initial begin
    rx_o = '{1'b0, 8'h00};
    tx_ready_o = 1'b1;
  end
  // slow mode takes one reply byte in three
  always @(posedge mclk_i) begin
    ph_r <= (!rst_b_i || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    tx_ready_o <= !stall_i || ph_r == 2'h0;
  end
  task automatic send_byte(input logic [7:0] b);
    @(posedge mclk_i);
    rx_o <= '{1'b1, b};
    @(negedge mclk_i);
    while (!rx_ready_i) @(negedge mclk_i);
    @(posedge mclk_i);
    // released line shows the inverse, never the stale byte
    rx_o <= '{1'b0, ~b};
  endtask
  // every reply byte is read out, so pairs stay whole
  task automatic get_byte(output logic [7:0] b, output logic got);
    got = 1'b0;
    b = 8'h00;
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge mclk_i);
      if (tx_valid_i && tx_ready_o) begin
        got = 1'b1;
        b = tx_data_i;
      end
    end
    @(posedge mclk_i);
  endtask
endmodule // host_link_model

// ==== tb/debug_command_interpreter_tb_top.sv ====
// self-checking bench of the debug command interpreter
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module debug_command_interpreter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dbg_cmd_pkg::*;
  localparam logic [15:0] REV = 16'ha55a;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic read_protect_i = 1'b0;
  logic [7:0] debug_status_register_i = 8'h00;
  logic cpu_running_i = 1'b0;
  logic stall_i = 1'b0;
  byte_strobe_t rx_i;
  logic rx_ready_o, tx_valid_o, tx_ready_i;
  logic [7:0] tx_data_o, debug_control_register_o, st, d, b, ctl;
  logic [15:0] w;
  logic g;
  logic [7:0] ext_seen = 8'h00;
  cmd_pulses_t cmd_pulse_o;
  int err_count = 0, n_checks = 0, cyc = 0, txv = 0, seed = 32'h86e7_f5e1;
  int pc[5] = '{default: 0};
  always #4 mclk_i = ~mclk_i;
  debug_command_interpreter #(.REVISION(REV), .CNT_WIDTH(16)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .rx_i(rx_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .read_protect_i(read_protect_i), .debug_status_register_i(debug_status_register_i),
    .cpu_running_i(cpu_running_i), .debug_control_register_o(debug_control_register_o),
    .cmd_pulse_o(cmd_pulse_o));
  host_link_model host (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .rx_o(rx_i), .rx_ready_i(rx_ready_o),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .stall_i(stall_i));
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    // unknown strobes count as strobes so they cannot hide
    pc[0] += (cmd_pulse_o.crc_start !== 1'b0);
    pc[1] += (cmd_pulse_o.step !== 1'b0);
    pc[2] += (cmd_pulse_o.stuff !== 1'b0);
    pc[3] += (cmd_pulse_o.exec !== 1'b0);
    pc[4] += (cmd_pulse_o.ext_cmd !== 1'b0);
    if (cmd_pulse_o.ext_cmd !== 1'b0) ext_seen = cmd_pulse_o.ext_code;
    txv += (tx_valid_o !== 1'b0);
    if (cyc == 90000) begin
      err_count++;
      wrap_up();
    end
  end
  function automatic logic [7:0] ctl_exp(logic [7:0] old, logic [7:0] nw, logic prot);
    return prot ? {old[7] | nw[7], nw[6:0]} : nw;
  endfunction
  task automatic rd2(input logic [7:0] c, output logic [15:0] v);
    logic k;
    host.send_byte(c);
    host.get_byte(v[15:8], k);
    `CHK("first byte", 1'b1, k)
    host.get_byte(v[7:0], k);
    `CHK("second byte", 1'b1, k)
  endtask
  task automatic pulse_chk(input logic [7:0] c, input int idx, input int n);
    int p0;
    int t0;
    p0 = pc[idx];
    t0 = txv;
    host.send_byte(c);
    repeat (4) @(posedge mclk_i);
    `CHK("pulse count", n, pc[idx] - p0)
    `CHK("no reply", t0, txv)
    `CHK("ready again", 1'b1, rx_ready_o)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      stall_i <= s[0];
      rd2(8'h00, w);
      `CHK("revision", REV, w)
    end
    $display("test revision done");
    repeat (6) begin
      st = 8'($random(seed));
      debug_status_register_i <= st;
      host.send_byte(8'h02);
      host.get_byte(b, g);
      `CHK("status", st, b)
    end
    $display("test status done");
    ctl = 8'h00;
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      if (i == 4) d[7] = 1'b1;
      if (i == 5) d[7] = 1'b0;
      read_protect_i <= (i >= 4);
      host.send_byte(8'h04);
      host.send_byte(d);
      repeat (2) @(posedge mclk_i);
      ctl = ctl_exp(ctl, d, i >= 4);
      `CHK("control", ctl, debug_control_register_o)
    end
    $display("test control done");
    for (int i = 0; i < 2; i++) begin
      read_protect_i <= (i == 1);
      for (int k = 0; k < 3; k++) pulse_chk(8'h10 + 8'(k), k + 1, i == 0);
    end
    pulse_chk(8'h0e, 0, 1);
    pulse_chk(8'h0f, 4, 0);
    pulse_chk(8'hff, 4, 0);
    d = 8'h05 + 8'($unsigned($random(seed)) % 9);
    pulse_chk(d, 4, 1);
    `CHK("ext code", d, ext_seen)
    repeat (4) pulse_chk(8'h13 + 8'($unsigned($random(seed)) % 237), 4, 0);
    $display("test command codes done");
    read_protect_i <= 1'b0;
    cpu_running_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    cpu_running_i <= 1'b0;
    rd2(8'h03, w);
    `CHK("count range", 1'b1, w >= 16'h0012 && w <= 16'h0015)
    foreach (pc[i]) if (i < 3) begin
      cpu_running_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      cpu_running_i <= 1'b0;
      pulse_chk(i == 0 ? 8'h08 : (i == 1 ? 8'h0e : 8'h10), 4, i == 0);
      rd2(8'h03, w);
      `CHK("overwritten count", 16'h0000, w)
    end
    cpu_running_i <= 1'b1;
    repeat (65545) @(posedge mclk_i);
    cpu_running_i <= 1'b0;
    rd2(8'h03, w);
    `CHK("saturated count", 16'hffff, w)
    $display("test counter done");
    rst_b_i <= 1'b0;
    @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    `CHK("control after reset", 8'h00, debug_control_register_o)
    $display("test reset done");
    wrap_up();
  end
endmodule // debug_command_interpreter_tb_top
